// [design/ccg_pkg.sv]
// Package for the processor clock, ready and reset generator
package ccg_pkg;

  // Divide-by-three counter
  localparam int unsigned DIV_RATIO     = 3;
  localparam logic [1:0]  DIV_LAST      = 2'h2;
  localparam logic [1:0]  DIV_RESET     = 2'h0;
  localparam logic        CLK_RESET     = 1'h0;
  localparam logic        PCLK_RESET    = 1'h0;
  localparam logic        RESET_OUT_RST = 1'h1;
  localparam logic        READY_RESET   = 1'h0;

  // Source oscillator enable pulses and straps
  typedef struct packed {
    logic osc_tick;     // Crystal oscillator tick
    logic efi_tick;     // External frequency tick
    logic source_sel;   // High selects external source
    logic divider_hold; // Counter clear
  } ccg_src_t;

  // Ready inputs as a group
  typedef struct packed {
    logic bus_done_a;
    logic ready_qual_a_n;
    logic bus_done_b;
    logic ready_qual_b_n;
    logic sync_depth_sel;
  } ccg_rdy_t;

  // Clock phase events derived from the divided clock
  typedef enum logic [1:0] {
    CCG_PH_HIGH = 2'b00,
    CCG_PH_LOW1 = 2'b01,
    CCG_PH_LOW2 = 2'b11
  } ccg_phase_t;

endpackage

// [design/ccg_clock_gen.sv]
// Clock, ready and reset generator core
`timescale 1ns/1ps
module ccg_clock_gen (
  input  wire logic             CLK_I,
  input  wire logic             RESET_N_I,
  input  wire logic             OSC_IN_I,
  input  wire logic             EXT_FREQ_IN_I,
  input  wire logic             SOURCE_SELECT_I,
  input  wire logic             DIVIDER_HOLD_I,
  input  wire logic             BUS_DONE_A_I,
  input  wire logic             READY_QUAL_A_N_I,
  input  wire logic             BUS_DONE_B_I,
  input  wire logic             READY_QUAL_B_N_I,
  input  wire logic             SYNC_DEPTH_SEL_I,
  input  wire logic             POWER_ON_CLEAR_N_I,
  output      logic             PROC_CLOCK_O,
  output      logic             PERIPH_CLOCK_O,
  output      logic             CRYSTAL_TAP_OUT_O,
  output      logic             READY_O,
  output      logic             PROC_RESET_O,
  output      ccg_pkg::ccg_phase_t PHASE_O
);
  import ccg_pkg::*;

  // Rising edge of a sampled level against its previous value
  function automatic logic rise_of(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // One bus-ready input gated by its active-low enable
  function automatic logic qual_ready(input logic done, input logic qual_n);
    return done & ~qual_n;
  endfunction

  // Register next value that loads only on an event
  function automatic logic load_on(input logic ev, input logic nxt,
                                   input logic cur);
    return ev ? nxt : cur;
  endfunction

  // Pin synchronizers, two flops each
  // Every pin is asynchronous to CLK_I, so only stage two is read.
  // Sources must stay well below a quarter of CLK_I so that each
  // level of the crystal or external wave is seen more than once.
  localparam int unsigned NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;

  assign pin_raw = {OSC_IN_I, EXT_FREQ_IN_I, SOURCE_SELECT_I,
                    DIVIDER_HOLD_I, BUS_DONE_A_I, READY_QUAL_A_N_I,
                    BUS_DONE_B_I, READY_QUAL_B_N_I, SYNC_DEPTH_SEL_I,
                    POWER_ON_CLEAR_N_I};

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Grouped synchronized inputs
  ccg_src_t src;
  ccg_rdy_t rdy;
  logic     por_n;
  assign src = pin_s2_q[9:6];
  assign rdy = pin_s2_q[5:1];
  assign por_n = pin_s2_q[0];

  // Rising-edge detection of the oscillator sources
  logic osc_prev_q;
  logic efi_prev_q;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      osc_prev_q <= 1'h0;
      efi_prev_q <= 1'h0;
    end else begin
      osc_prev_q <= src.osc_tick;
      efi_prev_q <= src.efi_tick;
    end
  end

  // Source select and source tick
  logic src_tick;
  assign src_tick = src.source_sel ?
                    rise_of(src.efi_tick, efi_prev_q) :
                    rise_of(src.osc_tick, osc_prev_q);

  // Divider decode: wrap after the last count, else step by one
  logic       div_wrap;
  logic [1:0] div_step;
  logic [1:0] div_q;
  logic [1:0] div_d;
  assign div_wrap = (div_q == DIV_LAST);
  assign div_step = div_wrap ? DIV_RESET : div_q + 2'h1;

  // Divide-by-three counter with clear
  // Hold release restarts at count 0, so the clock goes high at once
  // and the first high phase after a release may be short.
  assign div_d = src.divider_hold ? DIV_RESET :
                 !src_tick        ? div_q : div_step;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) div_q <= DIV_RESET;
    else            div_q <= div_d;
  end

  // Processor clock high in the first third only
  logic pclk_q;
  logic pclk_d;
  assign pclk_d = (div_d == DIV_RESET) & ~src.divider_hold;

  // Edge events of the processor clock
  logic clk_rise;
  logic clk_fall;
  assign clk_rise = rise_of(pclk_d, pclk_q);
  assign clk_fall = rise_of(pclk_q, pclk_d);

  // Peripheral clock toggles on each processor clock rise
  // Forced low in hold so several generators restart in one phase
  logic perc_q;
  logic perc_d;
  assign perc_d = src.divider_hold ? PCLK_RESET :
                  clk_rise ? ~perc_q : perc_q;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pclk_q <= CLK_RESET;
      perc_q <= PCLK_RESET;
    end else begin
      pclk_q <= pclk_d;
      perc_q <= perc_d;
    end
  end

  // Qualified ready condition
  logic rdy_cond;
  assign rdy_cond = qual_ready(rdy.bus_done_a, rdy.ready_qual_a_n) |
                    qual_ready(rdy.bus_done_b, rdy.ready_qual_b_n);

  // Ready stage one on rise, stage two on fall
  // A falling condition clears stage two directly, since stage one
  // may still hold the old high until the next clock rise.
  logic st1_q;
  logic st1_d;
  logic st2_q;
  logic st2_d;
  logic st2_in;
  assign st1_d = load_on(clk_rise, rdy_cond, st1_q);
  assign st2_in = rdy.sync_depth_sel ? rdy_cond :
                  (st1_q & rdy_cond);
  assign st2_d = load_on(clk_fall, st2_in, st2_q);

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st1_q <= READY_RESET;
      st2_q <= READY_RESET;
    end else begin
      st1_q <= st1_d;
      st2_q <= st2_d;
    end
  end

  // Reset output caught on processor clock fall
  // The request synchronizer resets to 0, which reads as a request
  // until the pin has been seen high.
  logic rst_q;
  logic rst_d;
  assign rst_d = load_on(clk_fall, ~por_n, rst_q);

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) rst_q <= RESET_OUT_RST;
    else            rst_q <= rst_d;
  end

  // Phase of the divided clock
  // Observation only; follows the next count so it lines up with
  // the processor clock flip-flop.
  ccg_phase_t phase_q;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) phase_q <= CCG_PH_HIGH;
    else begin
      unique case (div_d)
        2'h0:    phase_q <= CCG_PH_HIGH;
        2'h1:    phase_q <= CCG_PH_LOW1;
        default: phase_q <= CCG_PH_LOW2;
      endcase
    end
  end

  // Outputs from flip-flops
  // No combinational path reaches a pin; the tap lags the crystal
  // by the synchronizer and edge-detect delay.
  assign PROC_CLOCK_O      = pclk_q;
  assign PERIPH_CLOCK_O    = perc_q;
  assign CRYSTAL_TAP_OUT_O = osc_prev_q;
  assign READY_O           = st2_q;
  assign PROC_RESET_O      = rst_q;
  assign PHASE_O           = phase_q;

endmodule

// [verification/ccg_clock_gen_chk.sv]
// Port assertions of the clock generator
`timescale 1ns/1ps
module ccg_chk (
  input logic CLK_I,
  input logic RESET_N_I,
  input logic DIVIDER_HOLD_I,
  input logic BUS_DONE_A_I,
  input logic READY_QUAL_A_N_I,
  input logic BUS_DONE_B_I,
  input logic READY_QUAL_B_N_I,
  input logic POWER_ON_CLEAR_N_I,
  input logic PROC_CLOCK_O,
  input logic PERIPH_CLOCK_O,
  input logic READY_O,
  input logic PROC_RESET_O
);
  // Qualified ready condition
  wire rdy_c = BUS_DONE_A_I & ~READY_QUAL_A_N_I
    | BUS_DONE_B_I & ~READY_QUAL_B_N_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I || DIVIDER_HOLD_I);
  // Ready condition raised and held; clock fall then rise
  sequence s_up; $rose(rdy_c) ##1 rdy_c [*8]; endsequence
  sequence s_rise; $fell(PROC_CLOCK_O) ##[1:30] $rose(PROC_CLOCK_O);
  endsequence
  // Timing relations at the ports
  a_ready_rise: assert property (s_up |-> ##[1:60] READY_O)
    else $error("ready late");
  a_ready_qual: assert property (!rdy_c [*8] |-> !$rose(READY_O))
    else $error("ready without condition");
  a_change_low: assert property
    ($changed({READY_O, PROC_RESET_O}) |-> !PROC_CLOCK_O)
    else $error("change while clock high");
  a_clk_high: assert property (s_rise |=> PROC_CLOCK_O [*5])
    else $error("short high");
  a_clk_low: assert property ($fell(PROC_CLOCK_O) |=>
    !PROC_CLOCK_O [*8]) else $error("short low");
  a_periph_hi: assert property ($rose(PERIPH_CLOCK_O) |=>
    PERIPH_CLOCK_O [*8]) else $error("short peripheral high");
  a_hold_clear: assert property (disable iff (!RESET_N_I)
    DIVIDER_HOLD_I [*6] |-> !PROC_CLOCK_O && !PERIPH_CLOCK_O)
    else $error("counters not held");
  a_reset_set: assert property
    ($fell(POWER_ON_CLEAR_N_I) |-> ##[1:60] PROC_RESET_O)
    else $error("reset late");
endmodule
bind ccg_clock_gen ccg_chk u_chk (.*);

// [verification/ccg_src_model.sv]
// Crystal and external frequency sources
`timescale 1ns/1ps
module ccg_src_model (
  input  wire logic clk_i,
  output      logic osc_o,
  output      logic efi_o
);
  logic [4:0] cnt_q = 5'h00;
  // Shared count: crystal period 6, external period 8
  always_ff @(posedge clk_i) begin
    cnt_q <= (cnt_q == 5'h17) ? 5'h00 : cnt_q + 5'h01;
  end
  assign osc_o = (cnt_q % 5'h06) < 5'h03;
  assign efi_o = cnt_q[2];
endmodule

// [verification/tb.sv]
// Self-checking bench of the clock generator
`timescale 1ns/1ps
module tb;
  import ccg_pkg::*;
  logic CLK_I, RESET_N_I, SOURCE_SELECT_I, DIVIDER_HOLD_I, BUS_DONE_A_I;
  logic READY_QUAL_A_N_I, BUS_DONE_B_I, READY_QUAL_B_N_I, SYNC_DEPTH_SEL_I;
  logic POWER_ON_CLEAR_N_I, OSC_IN_I, EXT_FREQ_IN_I, PROC_CLOCK_O;
  logic PERIPH_CLOCK_O, CRYSTAL_TAP_OUT_O, READY_O, PROC_RESET_O;
  ccg_phase_t PHASE_O;
  int n_mismatch = 0, n_tests = 0, cyc = 0, hi, per;
  // Rows: strap, high cycles, period cycles
  int srows [2][3] = '{'{0, 6, 18}, '{1, 8, 24}};
  // Rows: done a, qual a, done b, qual b, ready
  logic [4:0] rrows [5] = '{5'h17, 5'h1e, 5'h1d, 5'h0a, 5'h15};
  wire src = SOURCE_SELECT_I ? EXT_FREQ_IN_I : OSC_IN_I;
  ccg_src_model u_src (.clk_i(CLK_I), .osc_o(OSC_IN_I),
    .efi_o(EXT_FREQ_IN_I));
  ccg_clock_gen dut (.*);
  task chk(string nm, logic [7:0] s, logic [7:0] e);
    n_tests++;
    n_mismatch += (s !== e);
    if (s !== e) $display("unexpected %s: expected %0h seen %0h", nm, e, s);
  endtask
  task results;
    $display("%0d mismatches in %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Waits and counts on the processor clock
  task meas;
    @(negedge CLK_I iff !PROC_CLOCK_O);
    @(negedge CLK_I iff PROC_CLOCK_O);
    for (hi = 0; PROC_CLOCK_O; hi++) @(negedge CLK_I);
    for (per = hi; !PROC_CLOCK_O; per++) @(negedge CLK_I);
  endtask
  task tail;
    @(negedge CLK_I iff !PROC_CLOCK_O);
    repeat (4) @(negedge CLK_I);
  endtask
  task pcyc;
    @(negedge CLK_I iff !PROC_CLOCK_O);
    @(negedge CLK_I iff PROC_CLOCK_O);
    tail();
  endtask
  initial begin
    CLK_I = 0;
    forever #10 CLK_I = ~CLK_I;
  end
  // Cycle ceiling against a hang
  always @(posedge CLK_I) if (++cyc == 5000) begin
    n_mismatch++;
    results();
  end
  initial begin
    {RESET_N_I, SOURCE_SELECT_I, DIVIDER_HOLD_I, BUS_DONE_A_I, BUS_DONE_B_I,
      READY_QUAL_A_N_I, READY_QUAL_B_N_I, POWER_ON_CLEAR_N_I,
      SYNC_DEPTH_SEL_I} = 9'h001;
    repeat (4) @(posedge CLK_I);
    chk("reset out", PROC_RESET_O, 1);
    chk("phase", PHASE_O, CCG_PH_HIGH);
    RESET_N_I <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK_I) DIVIDER_HOLD_I <= 1'h1;
      SOURCE_SELECT_I <= srows[i][0][0];
      repeat (8) @(negedge CLK_I);
      chk("held clock", PROC_CLOCK_O, 0);
      @(posedge src) @(posedge CLK_I) DIVIDER_HOLD_I <= 1'h0;
      meas();
      meas();
      chk("high", hi, srows[i][1]);
      chk("period", per, srows[i][2]);
      chk("phase high", PHASE_O, CCG_PH_HIGH);
      repeat (hi) @(negedge CLK_I);
      chk("phase low", PHASE_O, CCG_PH_LOW1);
      @(negedge CLK_I iff !PERIPH_CLOCK_O);
      @(negedge CLK_I iff PERIPH_CLOCK_O);
      for (hi = 0; PERIPH_CLOCK_O; hi++) @(negedge CLK_I);
      chk("periph high", hi, srows[i][2]);
    end
    @(negedge CLK_I iff !CRYSTAL_TAP_OUT_O);
    @(negedge CLK_I iff CRYSTAL_TAP_OUT_O);
    for (hi = 0; CRYSTAL_TAP_OUT_O; hi++) @(negedge CLK_I);
    chk("tap high", hi, 3);
    foreach (rrows[i]) begin
      @(posedge CLK_I) {BUS_DONE_A_I, READY_QUAL_A_N_I, BUS_DONE_B_I,
        READY_QUAL_B_N_I} <= rrows[i][4:1];
      pcyc();
      chk("ready row", READY_O, rrows[i][0]);
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge CLK_I) {BUS_DONE_A_I, BUS_DONE_B_I} <= 2'h0;
      SYNC_DEPTH_SEL_I <= m[0];
      pcyc();
      @(negedge CLK_I iff PROC_CLOCK_O);
      @(posedge CLK_I) BUS_DONE_A_I <= 1'h1;
      tail();
      chk("ready first fall", READY_O, m[0]);
      pcyc();
      chk("ready second fall", READY_O, 1);
      @(posedge CLK_I) BUS_DONE_A_I <= 1'h0;
      pcyc();
      chk("ready dropped", READY_O, 0);
    end
    @(posedge CLK_I) POWER_ON_CLEAR_N_I <= 1'h1;
    pcyc();
    chk("reset released", PROC_RESET_O, 0);
    @(posedge CLK_I) POWER_ON_CLEAR_N_I <= 1'h0;
    pcyc();
    chk("reset raised", PROC_RESET_O, 1);
    results();
  end
endmodule
